//--- hw/dlis_map.vh
// Purpose: Constants for the link initiator status block
// Assumes: Register port with 8-bit data, byte offsets
// Notes: Offsets other than the error status register are local choices
`ifndef DLIS_MAP_VH
`define DLIS_MAP_VH
`define DLIS_OFF_TIMEOUT_CTL 8'hd9
`define DLIS_OFF_ERR_STAT 8'hda
`define DLIS_OFF_BUSY_STAT 8'hdb
`define DLIS_OFF_REC_HI 8'hdc
`define DLIS_OFF_REC_LO 8'hdd
`define DLIS_OFF_MODE 8'hd8
`define DLIS_BIT_ERROR_SUMMARY_FLAG 7
`define DLIS_BIT_ACKERR 6
`define DLIS_BIT_CANCEL 5
`define DLIS_BIT_TIMEOUT 4
`define DLIS_BIT_TGTERR 3
`define DLIS_BIT_PARERR 2
`define DLIS_BIT_IRQEN 7
`define DLIS_BIT_IRQMIR 7
`define DLIS_BIT_BUSY 6
`define DLIS_BIT_LOCK 0
`define DLIS_BIT_SPECIAL 1
`define DLIS_RST_BYTE 8'h00
`define DLIS_RST_LIMIT 4'h0
`endif

//--- hw/dlis_top.v
// Purpose: Status, timeout and transaction record of a die-to-die link initiator
// Assumes: Transaction sequencer supplies start/last/ack pulses on sys_clk
// Notes: Link clock and pins are sampled by sys_clk through two flip-flops
//
// Operation
// - Count link clock cycles after last transfer; timeout when count exceeds limit.
// - Timeout limit writes only once after enable in normal mode; always in special.
// - Limit zero: acknowledge must come in the cycle right after the last transfer.
// - Nonzero limit: up to that many wait states allowed before timeout.
// - Error summary flag set by any error; drives unmaskable error interrupt.
// - Writing one clears the error summary flag; zero leaves it.
// - Ack wire error set when any data lane in data_lanes_used (data bits 3:0) is low at acknowledge.
// - Cancel flag set when a request is replaced by idle while error pending.
// - Timeout error flag set on acknowledge timeout.
// - Target error flag set when target error signal high at acknowledge.
// - Parity error flag set on parity mismatch at acknowledge.
// - Received parity bits shown in status bits 1 and 0.
// - Specific error flags clear only with the summary flag clear.
// - Interrupt mirror bit follows the target interrupt line level.
// - Busy bit is one during a transaction, zero when idle.
// - Transaction record loads at the start of each new transaction.
// - Record bit 15 holds direction, one for read.
// - Record bit 14 is one for eight-bit data.
// - Record bit 12 is one for non-blocking mode.
// - Control bit 7 enables the external interrupt request.
// - While summary flag set, records freeze and requests become idle.
// - Record low byte holds the window-relative address.
// - Timeout sets summary and timeout flags together.
`timescale 1ns/1ps
`include "dlis_map.vh"
module dlis_top (
	// Clock, reset, enable
	input wire sys_clk,
	input wire rst,
	input wire clk_en,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_reg,
	// Link pins
	input wire link_clock,
	input wire [7:0] link_data_in,
	input wire [1:0] link_parity_in,
	input wire link_target_err,
	input wire target_irq_line,
	// Sequencer
	input wire xfer_req,
	input wire xfer_read,
	input wire xfer_byte,
	input wire xfer_xfer_nonblocking,
	input wire [7:0] xfer_addr,
	input wire xfer_last,
	input wire [3:0] data_lanes_used,
	input wire [1:0] expected_parity,
	input wire ack_seen,
	output reg xfer_go_reg,
	output reg xfer_done_reg,
	// Interrupts to processor
	output reg link_error_irq_reg,
	output reg ext_irq_req_reg
);
	localparam ST_IDLE = 3'b001;
	localparam ST_XFER = 3'b010;
	localparam ST_WAIT = 3'b100;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [1:0] lclk_sync_reg;
	reg lclk_prev_reg;
	reg [1:0] irq_sync_reg;
	reg [1:0] err_sync_reg;
	reg [7:0] data_s1_reg;
	reg [7:0] data_s2_reg;
	reg [1:0] par_s1_reg;
	reg [1:0] par_s2_reg;
	reg [3:0] ack_wait_limit_reg;
	reg ext_irq_enable_reg;
	reg limit_locked_reg;
	reg special_mode_reg;
	reg link_enabled_reg;
	reg error_summary_flag_reg;
	reg ack_wire_error_flag_reg;
	reg cancel_flag_reg;
	reg timeout_error_flag_reg;
	reg target_error_flag_reg;
	reg parity_error_flag_reg;
	reg rx_parity_hi_reg;
	reg rx_parity_lo_reg;
	reg [15:0] record_reg;
	reg [4:0] wait_cnt_reg;
	wire lclk_rise;
	wire clr_err;
	wire timeout_hit;
	wire ack_now;
	wire ack_wire_bad;
	wire par_bad;
	wire tgt_bad;
	wire any_err;

	function is_reg_hit;
		input [7:0] a;
		input [7:0] off;
		is_reg_hit = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second
	always @(posedge sys_clk) begin
		if (rst) begin
			lclk_sync_reg <= 2'h0;
			lclk_prev_reg <= 1'b0;
			irq_sync_reg <= 2'h0;
			err_sync_reg <= 2'h0;
			data_s1_reg <= 8'h00;
			data_s2_reg <= 8'h00;
			par_s1_reg <= 2'h0;
			par_s2_reg <= 2'h0;
		end else if (clk_en) begin
			lclk_sync_reg <= {lclk_sync_reg[0], link_clock};
			lclk_prev_reg <= lclk_sync_reg[1];
			irq_sync_reg <= {irq_sync_reg[0], target_irq_line};
			err_sync_reg <= {err_sync_reg[0], link_target_err};
			data_s1_reg <= link_data_in;
			data_s2_reg <= data_s1_reg;
			par_s1_reg <= link_parity_in;
			par_s2_reg <= par_s1_reg;
		end
	end

	assign lclk_rise = lclk_sync_reg[1] & ~lclk_prev_reg;
	assign clr_err = reg_wr & is_reg_hit(reg_addr, `DLIS_OFF_ERR_STAT)
		& reg_wdata[`DLIS_BIT_ERROR_SUMMARY_FLAG];
	// Wait count exceeds limit: zero limit leaves no wait cycle
	assign timeout_hit = (state_reg == ST_WAIT) & lclk_rise & ~ack_seen
		& (wait_cnt_reg > {1'b0, ack_wait_limit_reg});
	assign ack_now = (state_reg == ST_WAIT) & ack_seen;
	// Only the lanes in use must read high; narrow links leave upper pins open
	assign ack_wire_bad = ack_now & ((data_s2_reg[3:0] & data_lanes_used)
		!= data_lanes_used);
	assign par_bad = ack_now & (par_s2_reg != expected_parity);
	assign tgt_bad = ack_now & err_sync_reg[1];
	assign any_err = timeout_hit | ack_wire_bad | par_bad | tgt_bad;

	////////////////////////////////////////////////////////////////////////
	// Transaction state
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (xfer_req & ~error_summary_flag_reg & link_enabled_reg)
					state_next = ST_XFER;
			end
			ST_XFER: begin
				if (xfer_last)
					state_next = ST_WAIT;
			end
			ST_WAIT: begin
				if (ack_seen | timeout_hit)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			wait_cnt_reg <= 5'h00;
			xfer_go_reg <= 1'b0;
			xfer_done_reg <= 1'b0;
			record_reg <= 16'h0000;
		end else if (clk_en) begin
			state_reg <= state_next;
			xfer_go_reg <= (state_reg == ST_IDLE) & (state_next == ST_XFER);
			xfer_done_reg <= (state_reg == ST_WAIT) & (state_next == ST_IDLE);
			if (state_reg != ST_WAIT)
				wait_cnt_reg <= 5'h00;
			else if (lclk_rise & (wait_cnt_reg != 5'h1f))
				wait_cnt_reg <= wait_cnt_reg + 5'h01;
			// Record frozen while an error is pending
			if ((state_reg == ST_IDLE) & (state_next == ST_XFER))
				record_reg <= {xfer_read, xfer_byte, 1'b0, xfer_xfer_nonblocking,
					4'h0, xfer_addr};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always @(posedge sys_clk) begin
		if (rst) begin
			ack_wait_limit_reg <= `DLIS_RST_LIMIT;
			ext_irq_enable_reg <= 1'b0;
			limit_locked_reg <= 1'b0;
			special_mode_reg <= 1'b0;
			link_enabled_reg <= 1'b0;
		end else if (clk_en) begin
			if (reg_wr & is_reg_hit(reg_addr, `DLIS_OFF_MODE)) begin
				link_enabled_reg <= link_enabled_reg | reg_wdata[`DLIS_BIT_LOCK];
				special_mode_reg <= reg_wdata[`DLIS_BIT_SPECIAL];
			end
			if (reg_wr & is_reg_hit(reg_addr, `DLIS_OFF_TIMEOUT_CTL)) begin
				ext_irq_enable_reg <= reg_wdata[`DLIS_BIT_IRQEN];
				// First write after enable sticks in normal mode
				if (~limit_locked_reg | special_mode_reg) begin
					ack_wait_limit_reg <= reg_wdata[3:0];
					if (link_enabled_reg)
						limit_locked_reg <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Error flags: a new error in the clear cycle wins
	always @(posedge sys_clk) begin
		if (rst) begin
			error_summary_flag_reg <= 1'b0;
			ack_wire_error_flag_reg <= 1'b0;
			cancel_flag_reg <= 1'b0;
			timeout_error_flag_reg <= 1'b0;
			target_error_flag_reg <= 1'b0;
			parity_error_flag_reg <= 1'b0;
			rx_parity_hi_reg <= 1'b0;
			rx_parity_lo_reg <= 1'b0;
		end else if (clk_en) begin
			if (clr_err) begin
				error_summary_flag_reg <= 1'b0;
				ack_wire_error_flag_reg <= 1'b0;
				cancel_flag_reg <= 1'b0;
				timeout_error_flag_reg <= 1'b0;
				target_error_flag_reg <= 1'b0;
				parity_error_flag_reg <= 1'b0;
			end
			if (any_err)
				error_summary_flag_reg <= 1'b1;
			if (ack_wire_bad)
				ack_wire_error_flag_reg <= 1'b1;
			if (timeout_hit)
				timeout_error_flag_reg <= 1'b1;
			if (tgt_bad)
				target_error_flag_reg <= 1'b1;
			if (par_bad)
				parity_error_flag_reg <= 1'b1;
			// Dropped request shows as cancel
			if ((state_reg == ST_IDLE) & xfer_req & error_summary_flag_reg) begin
				cancel_flag_reg <= 1'b1;
				error_summary_flag_reg <= 1'b1;
			end
			if (ack_now) begin
				rx_parity_hi_reg <= par_s2_reg[1];
				rx_parity_lo_reg <= par_s2_reg[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port and interrupt outputs
	always @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata_reg <= `DLIS_RST_BYTE;
			link_error_irq_reg <= 1'b0;
			ext_irq_req_reg <= 1'b0;
		end else if (clk_en) begin
			link_error_irq_reg <= error_summary_flag_reg;
			ext_irq_req_reg <= ext_irq_enable_reg & irq_sync_reg[1];
			reg_rdata_reg <= `DLIS_RST_BYTE;
			if (reg_rd) begin
				case (reg_addr)
					`DLIS_OFF_TIMEOUT_CTL:
						reg_rdata_reg <= {ext_irq_enable_reg, 3'h0, ack_wait_limit_reg};
					`DLIS_OFF_ERR_STAT:
						reg_rdata_reg <= {error_summary_flag_reg, ack_wire_error_flag_reg,
							cancel_flag_reg, timeout_error_flag_reg,
							target_error_flag_reg, parity_error_flag_reg,
							rx_parity_hi_reg, rx_parity_lo_reg};
					`DLIS_OFF_BUSY_STAT:
						reg_rdata_reg <= {irq_sync_reg[1],
							(state_reg != ST_IDLE), 6'h00};
					`DLIS_OFF_REC_HI: reg_rdata_reg <= record_reg[15:8];
					`DLIS_OFF_REC_LO: reg_rdata_reg <= record_reg[7:0];
					`DLIS_OFF_MODE:
						reg_rdata_reg <= {6'h00, special_mode_reg, link_enabled_reg};
					default: reg_rdata_reg <= `DLIS_RST_BYTE;
				endcase
			end
		end
	end
endmodule // dlis_top

//--- bench/dlis_props.sv
// Purpose: Port assertions for the link status block
// Assumes: One sys_clk domain, clk_en held high
// Notes: Flag state is seen only through the irq outputs
`timescale 1ns/1ps
module dlis_props (
	// Clock, reset
	input wire sys_clk,
	input wire rst,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_reg,
	// Link and sequencer
	input wire target_irq_line,
	input wire xfer_req,
	input wire xfer_last,
	input wire xfer_go_reg,
	input wire xfer_done_reg,
	input wire link_error_irq_reg,
	input wire ext_irq_req_reg
);
////////////////////////////////
// Busy copy lags the design by a cycle, so edges of it are excluded below
reg busy_reg = 1'b0;
wire clr_wr = reg_wr && reg_addr == 8'hda && reg_wdata[7];
wire rd_st1 = reg_rd && reg_addr == 8'hdb;
always @(posedge sys_clk) busy_reg <= !rst && (xfer_go_reg || (busy_reg && !xfer_done_reg));
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
sequence s_irq_low; !target_irq_line [*4]; endsequence
sequence s_pend_req; link_error_irq_reg && xfer_req; endsequence
a_err_hold: assert property (link_error_irq_reg && !clr_wr && !$past(clr_wr) |=> link_error_irq_reg)
	else $error("error flag lost");
a_err_clear: assert property (clr_wr && !xfer_req && !busy_reg && !xfer_go_reg |=> ##1 !link_error_irq_reg)
	else $error("error flag kept");
a_no_go_err: assert property (s_pend_req |=> !xfer_go_reg)
	else $error("start with error pending");
a_go_cause: assert property (xfer_go_reg |-> $past(xfer_req) && !busy_reg)
	else $error("start without request");
a_done_bound: assert property (xfer_last |-> ##[1:800] xfer_done_reg)
	else $error("no end after last transfer");
a_irq_gate: assert property (s_irq_low |-> !ext_irq_req_reg)
	else $error("irq request without line");
a_busy_set: assert property (rd_st1 && busy_reg && !xfer_done_reg |=> reg_rdata_reg[6])
	else $error("busy reads low");
a_busy_clear: assert property (rd_st1 && !busy_reg && !xfer_go_reg |=> !reg_rdata_reg[6])
	else $error("busy reads high");
endmodule // dlis_props
bind dlis_top dlis_props CHK (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
	.target_irq_line(target_irq_line), .xfer_req(xfer_req), .xfer_last(xfer_last),
	.xfer_go_reg(xfer_go_reg), .xfer_done_reg(xfer_done_reg),
	.link_error_irq_reg(link_error_irq_reg), .ext_irq_req_reg(ext_irq_req_reg));

//--- bench/dlis_target.sv
// Purpose: Far-side target model
// Assumes: Bench holds data and parity pins steady around each acknowledge
// Notes: Ack lags three cycles so the synced pins settle first
`timescale 1ns/1ps
module dlis_target (
	// Clock
	input wire sys_clk,
	// Bench controls
	input wire ack_go,
	input wire mute,
	input wire terr,
	input wire irq_set,
	// Far-side pins
	output reg link_clock,
	output wire ack_seen,
	output reg link_target_err,
	output reg target_irq_line
);
////////////////////////////////
reg [2:0] ack_pipe_reg = 3'h0;
initial link_clock = 1'b0;
initial link_target_err = 1'b0;
initial target_irq_line = 1'b0;
always #62.5 link_clock = ~link_clock;
// Prompt ack, well inside any limit; mute stands for a lost one
always @(posedge sys_clk) ack_pipe_reg <= {ack_pipe_reg[1:0], ack_go && !mute};
assign ack_seen = ack_pipe_reg[2];
always @(posedge sys_clk) link_target_err <= terr;
// Only the target's own sequence drops the line
always @(posedge sys_clk) target_irq_line <= irq_set;
endmodule // dlis_target

//--- bench/dlis_top_test.sv
// Purpose: Self-checking bench for the link status block
// Assumes: Far side modelled by dlis_target
// Notes: Limit set to 2 so timeouts stay short
`timescale 1ns/1ps
module dlis_top_test;
reg sys_clk = 1'b0;
reg rst = 1'b1;
reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, xfer_addr = 8'h00, lanes = 8'hff;
reg reg_wr = 0, reg_rd = 0, xfer_req = 0, xfer_read = 0, xfer_byte = 0, xfer_xfer_nonblocking = 0;
reg xfer_last = 0, ack_go = 0, mute = 0, terr = 0, irq_set = 0;
reg [1:0] par = 2'b01, exp_par = 2'b01;
wire [7:0] reg_rdata_reg;
wire link_clock, ack_seen, link_target_err, target_irq_line, go, done, err_irq, ext_irq;
integer miscompares = 0, check_count = 0, i, n;
always #2 sys_clk = ~sys_clk;
dlis_target FAR (.sys_clk(sys_clk), .ack_go(ack_go), .mute(mute), .terr(terr),
	.irq_set(irq_set), .link_clock(link_clock), .ack_seen(ack_seen),
	.link_target_err(link_target_err), .target_irq_line(target_irq_line));
dlis_top DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
	.link_clock(link_clock), .link_data_in(lanes), .link_parity_in(par),
	.link_target_err(link_target_err), .target_irq_line(target_irq_line), .xfer_req(xfer_req),
	.xfer_read(xfer_read), .xfer_byte(xfer_byte), .xfer_xfer_nonblocking(xfer_xfer_nonblocking), .xfer_addr(xfer_addr),
	.xfer_last(xfer_last), .data_lanes_used(4'hf), .expected_parity(exp_par),
	.ack_seen(ack_seen), .xfer_go_reg(go), .xfer_done_reg(done),
	.link_error_irq_reg(err_irq), .ext_irq_req_reg(ext_irq));
////////////////////////////////
task tally_and_finish;
	$display("checks %0d mismatches %0d", check_count, miscompares);
	if (miscompares == 0 && check_count > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
task chk(input [7:0] got, exp);
	check_count = check_count + 1;
	if (got !== exp) begin
		miscompares = miscompares + 1;
		$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
	end
endtask
task wr(input [7:0] a, d);
	@(posedge sys_clk);
	reg_wr <= 1;
	reg_addr <= a;
	reg_wdata <= d;
	@(posedge sys_clk);
	reg_wr <= 0;
endtask
task rd(input [7:0] a, m, e);
	@(posedge sys_clk);
	reg_rd <= 1;
	reg_addr <= a;
	@(posedge sys_clk);
	reg_rd <= 0;
	#1 chk(reg_rdata_reg & m, e);
endtask
// Bounded wait for start (0) or end (1); a hang ends the run
task wt(input s);
	for (n = 0; n < 3000 && (s ? done : go) !== 1'b1; n = n + 1) begin
		@(posedge sys_clk);
		#1;
	end
	if (n == 3000) begin
		miscompares = miscompares + 1;
		tally_and_finish;
	end
endtask
task xact(input r, b, k, input [7:0] a);
	@(posedge sys_clk);
	xfer_req <= 1;
	xfer_read <= r;
	xfer_byte <= b;
	xfer_xfer_nonblocking <= k;
	xfer_addr <= a;
	wt(0);
	@(posedge sys_clk);
	xfer_req <= 0;
	rd(8'hdb, 8'h40, 8'h40);
	@(posedge sys_clk);
	xfer_last <= 1;
	ack_go <= 1;
	@(posedge sys_clk);
	xfer_last <= 0;
	ack_go <= 0;
	wt(1);
endtask
////////////////////////////////
initial begin
	repeat (10) @(posedge sys_clk);
	rst <= 0;
	@(posedge sys_clk);
	for (i = 8'hd8; i < 8'hdf; i = i + 1) rd(i[7:0], 8'hff, 8'h00);
	$display("test reset done");
	wr(8'hd8, 8'h01);
	wr(8'hd9, 8'h83);
	wr(8'hd9, 8'h85);
	rd(8'hd9, 8'h0f, 8'h03);
	wr(8'hd8, 8'h03);
	wr(8'hd9, 8'h82);
	rd(8'hd9, 8'hff, 8'h82);
	wr(8'hd8, 8'h01);
	$display("test limit done");
	@(posedge sys_clk);
	par <= 2'b10;
	exp_par <= 2'b10;
	xact(1, 1, 0, 8'h5a);
	rd(8'hdc, 8'hff, 8'hc0);
	rd(8'hdd, 8'hff, 8'h5a);
	rd(8'hda, 8'hff, 8'h02);
	rd(8'hdb, 8'h40, 8'h00);
	$display("test good done");
	// Wire, target, parity and timeout errors in turn
	for (i = 0; i < 4; i = i + 1) begin
		@(posedge sys_clk);
		lanes <= (i == 0) ? 8'hf7 : 8'hff;
		terr <= (i == 1);
		par <= 2'b01;
		exp_par <= (i == 2) ? 2'b10 : 2'b01;
		mute <= (i == 3);
		xact(0, 0, 1, i[7:0]);
		rd(8'hda, 8'hff, {1'b1, i == 0, 1'b0, i == 3, i == 1, i == 2, 2'b01});
		chk({7'h00, err_irq}, 8'h01);
		rd(8'hdc, 8'hff, 8'h10);
		@(posedge sys_clk);
		xfer_req <= 1;
		xfer_read <= 1;
		xfer_addr <= 8'hee;
		repeat (4) @(posedge sys_clk);
		xfer_req <= 0;
		rd(8'hdd, 8'hff, i[7:0]);
		rd(8'hda, 8'ha0, 8'ha0);
		wr(8'hda, 8'h7f);
		rd(8'hda, 8'h80, 8'h80);
		wr(8'hda, 8'h80);
		rd(8'hda, 8'hfc, 8'h00);
		$display("test error %0d done", i);
	end
	// Zero limit with no acknowledge still times out
	wr(8'hd8, 8'h03);
	wr(8'hd9, 8'h80);
	xact(0, 0, 0, 8'h33);
	rd(8'hda, 8'hff, 8'h91);
	wr(8'hda, 8'h80);
	$display("test zero limit done");
	@(posedge sys_clk);
	irq_set <= 1;
	repeat (6) @(posedge sys_clk);
	rd(8'hdb, 8'hff, 8'h80);
	chk({7'h00, ext_irq}, 8'h01);
	wr(8'hdb, 8'hff);
	rd(8'hdb, 8'hff, 8'h80);
	@(posedge sys_clk);
	irq_set <= 0;
	repeat (6) @(posedge sys_clk);
	rd(8'hdb, 8'hff, 8'h00);
	$display("test irq done");
	tally_and_finish;
end
endmodule // dlis_top_test
